//--- rtl/pal_cfg.svh
// Offsets, field positions, reset values and limit spans of the power limit path.
// Assumes values are signed milli-dB (log units) or Q16.16 (linear units).
`ifndef PAL_CFG_SVH
`define PAL_CFG_SVH

// Register byte offsets
`define PAL_OFF_CTRL      8'h00
`define PAL_OFF_RES       8'h04
`define PAL_OFF_AVG_LEN   8'h08
`define PAL_OFF_CH_GAIN   8'h0c
`define PAL_OFF_CH_LOSS   8'h10
`define PAL_OFF_DISP_OFF  8'h14
`define PAL_OFF_LIM_UP    8'h18
`define PAL_OFF_LIM_LO    8'h1c
`define PAL_OFF_MATH_REF  8'h20
`define PAL_OFF_LOGIC_CFG 8'h24
`define PAL_OFF_AUTO_TAB  8'h28
`define PAL_OFF_STATUS    8'h2c
`define PAL_OFF_FCOUNT    8'h30
`define PAL_OFF_RESULT    8'h34
`define PAL_OFF_EFF_LEN   8'h38

// Status bit positions (write one to clear the first three)
`define PAL_ST_FAIL       0
`define PAL_ST_EVENT      1
`define PAL_ST_CNT_CLR    2
`define PAL_ST_RANGE      3
`define PAL_ST_SETTLED    4
`define PAL_ST_OVER       5
`define PAL_ST_UNDER      6

// Auto filter table write field
`define PAL_TAB_IDX_LSB   16

// Reset values
`define PAL_CTRL_RST      13'h0007
`define PAL_RES_RST       3'h3
`define PAL_AVG_LEN_RST   11'h001
`define PAL_TAB_RST       11'h004

// Filter length span
`define PAL_LEN_MIN       11'h001
`define PAL_LEN_MAX       11'h400

// Limit spans and defaults in milli-dB
`define PAL_DBM_MAX       32'sd230000
`define PAL_DBM_MIN       -32'sd150000
`define PAL_DBM_DEF_UP    32'sd90000
`define PAL_DBM_DEF_LO    -32'sd90000
`define PAL_DB_MAX        32'sd200000
`define PAL_DB_MIN        -32'sd180000
`define PAL_DB_DEF_UP     32'sd60000
`define PAL_DB_DEF_LO     -32'sd120000

// Fail counter width
`define PAL_FCNT_W        16

`endif

//--- rtl/pal_pkg.sv
// Types of the power limit path: datapath states and packed control carriers.
// Assumes pal_cfg.svh carries all numbers.
package pal_pkg;

  // Datapath states, Gray from ST_IDLE through ST_CHK; the return from ST_CHK to ST_IDLE flips two bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_ACC  = 3'h3,
    ST_DIV  = 3'h2,
    ST_CHK  = 3'h6
  } pal_state_e;

  // Control word, first field is the top bit
  typedef struct packed {
    logic       disp_off_en;
    logic       chan_off_en;
    logic [1:0] math_mode;
    logic       srq_en;
    logic       tdly_auto;
    logic       units_db;
    logic       units_lin;
    logic       lim_on;
    logic       range_manual;
    logic       range_auto;
    logic       avg_auto;
    logic       avg_on;
  } pal_ctrl_s;

  // One logic level limit output
  typedef struct packed {
    logic [1:0] src;
    logic       act_high;
    logic       en;
  } pal_lcfg_s;

endpackage : pal_pkg

//--- rtl/pal_avg_mem.sv
// Sample ring store of the averaging filter, registered read data.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module pal_avg_mem #(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input  wire logic          CLOCK_IN,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // Write port and registered read port
  always_ff @(posedge CLOCK_IN) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule : pal_avg_mem

//--- rtl/pal_div.sv
// Unsigned restoring divider, one quotient bit per clock, W+1 cycles total.
// Assumes start is ignored while busy; divisor zero yields all ones.
`timescale 1ns/1ps
module pal_div #(
  parameter int W = 44
) (
  input  wire logic         CLOCK_IN,
  input  wire logic         rst_b_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] dividend_in,
  input  wire logic [W-1:0] divisor_in,
  output logic              busy_out,
  output logic              done_out,
  output logic      [W-1:0] quot_out
);

  localparam int CW = $clog2(W + 1);

  logic [W:0]   rem_r;
  logic [W-1:0] dsr_r;
  logic [CW-1:0] cnt_r;
  wire  [W:0]   rem_sh = {rem_r[W-1:0], quot_out[W-1]};
  wire          ge     = rem_sh >= {1'b0, dsr_r};
  wire  [W:0]   rem_dn = rem_sh - {1'b0, dsr_r};

  // Shift-subtract sequence
  always_ff @(posedge CLOCK_IN) begin
    done_out <= 1'b0;
    if (!rst_b_in) begin
      rem_r    <= '0;
      dsr_r    <= '0;
      cnt_r    <= '0;
      busy_out <= 1'b0;
      quot_out <= '0;
    end else if (start_in && !busy_out) begin
      rem_r    <= '0;
      dsr_r    <= divisor_in;
      quot_out <= dividend_in;
      cnt_r    <= CW'(W);
      busy_out <= 1'b1;
    end else if (busy_out) begin
      rem_r    <= ge ? rem_dn : rem_sh;
      quot_out <= {quot_out[W-2:0], ge};
      cnt_r    <= cnt_r - 1'b1;
      if (cnt_r == CW'(1)) begin
        busy_out <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end

endmodule : pal_div

//--- rtl/pal_limit_path.sv
// Power meter channel post-processing: offset, averaging, math, display
// offset, limit check, fail count, service request and logic limit outputs.
// Assumes samples are synchronous to CLOCK_IN, one per SAMPLE_READY_OUT cycle.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pal_cfg.svh"
module pal_limit_path #(
  parameter logic signed [31:0] RANGE_SWITCH = 32'shffffc95e,
  parameter logic signed [31:0] BAND_TH0     = 32'shffff15a0,
  parameter logic signed [31:0] BAND_TH1     = 32'shffff8ad0,
  parameter logic signed [31:0] BAND_TH2     = 32'sh00000000
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  input  wire logic        SAMPLE_VALID_IN,
  input  wire logic [31:0] SAMPLE_IN,
  output logic             SAMPLE_READY_OUT,
  output logic      [31:0] RESULT_OUT,
  output logic             RESULT_VALID_OUT,
  output logic             RANGE_UPPER_OUT,
  output logic      [1:0]  LOGIC_OUT,
  output logic             SRQ_OUT
);

  localparam int SW = 44;
  localparam int RW = 40;

  // Address match used by the write decode; the read mux decodes ADDR_IN in its own case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Signed value within an inclusive span
  function automatic logic in_span(input logic signed [31:0] v,
                                   input logic signed [31:0] lo,
                                   input logic signed [31:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

  pal_pkg::pal_ctrl_s  ctrl_r;
  pal_pkg::pal_lcfg_s  [1:0] lcfg_r;
  pal_pkg::pal_state_e state_r;
  logic [2:0]          res_r;
  logic [10:0]         avg_len_r;
  logic [10:0]         tab_r [0:15];
  logic signed [31:0]  gain_r, loss_r, disp_off_r, lim_up_r, lim_lo_r, ref_r;
  logic signed [31:0]  samp_r, result_r;
  logic signed [SW-1:0] sum_r;
  logic [10:0]         fill_r, len_prev_r;
  logic [9:0]          wptr_r;
  logic                fail_r, event_r, over_r, under_r, range_upper_r;
  logic [`PAL_FCNT_W-1:0] fcount_r;
  logic                recip_to_gain_r;

  // Write decode
  wire wr_ctrl  = WR_IN && hit(ADDR_IN, `PAL_OFF_CTRL);
  wire wr_res   = WR_IN && hit(ADDR_IN, `PAL_OFF_RES);
  wire wr_len   = WR_IN && hit(ADDR_IN, `PAL_OFF_AVG_LEN);
  wire wr_gain  = WR_IN && hit(ADDR_IN, `PAL_OFF_CH_GAIN);
  wire wr_loss  = WR_IN && hit(ADDR_IN, `PAL_OFF_CH_LOSS);
  wire wr_disp  = WR_IN && hit(ADDR_IN, `PAL_OFF_DISP_OFF);
  wire wr_up    = WR_IN && hit(ADDR_IN, `PAL_OFF_LIM_UP);
  wire wr_lo    = WR_IN && hit(ADDR_IN, `PAL_OFF_LIM_LO);
  wire wr_ref   = WR_IN && hit(ADDR_IN, `PAL_OFF_MATH_REF);
  wire wr_lcfg  = WR_IN && hit(ADDR_IN, `PAL_OFF_LOGIC_CFG);
  wire wr_tab   = WR_IN && hit(ADDR_IN, `PAL_OFF_AUTO_TAB);
  wire wr_stat  = WR_IN && hit(ADDR_IN, `PAL_OFF_STATUS);
  wire pal_pkg::pal_ctrl_s ctrl_w = pal_pkg::pal_ctrl_s'(WDATA_IN[12:0]);
  wire signed [31:0] wval   = WDATA_IN;
  wire [10:0]        wlen   = WDATA_IN[10:0];
  wire               len_ok = (WDATA_IN[31:11] == '0) && (wlen >= `PAL_LEN_MIN)
                              && (wlen <= `PAL_LEN_MAX);

  // Limit span and defaults follow the window units
  wire signed [31:0] lim_max = ctrl_r.units_db ? `PAL_DB_MAX : `PAL_DBM_MAX;
  wire signed [31:0] lim_min = ctrl_r.units_db ? `PAL_DB_MIN : `PAL_DBM_MIN;
  wire lim_ok = ctrl_r.units_lin || in_span(wval, lim_min, lim_max);
  wire units_chg = wr_ctrl && (ctrl_w.units_db != ctrl_r.units_db) && !ctrl_w.units_lin;

  // Effective filter length: off, auto table or explicit
  wire [1:0]  band = (result_r >= BAND_TH2) ? 2'h3 : (result_r >= BAND_TH1) ? 2'h2 :
                     (result_r >= BAND_TH0) ? 2'h1 : 2'h0;
  wire [1:0]  res_idx = 2'(res_r - 3'h1);
  wire [10:0] len_eff = !ctrl_r.avg_on ? `PAL_LEN_MIN :
                        ctrl_r.avg_auto ? tab_r[{res_idx, band}] : avg_len_r;
  wire        settled = (fill_r >= len_eff);

  // Channel offset on the incoming reading
  wire signed [63:0] lin_prod = $signed(SAMPLE_IN) * gain_r;
  wire signed [31:0] samp_off = !ctrl_r.chan_off_en ? $signed(SAMPLE_IN) :
                                ctrl_r.units_lin ? lin_prod[47:16] :
                                $signed(SAMPLE_IN) + gain_r;
  wire take = SAMPLE_VALID_IN && SAMPLE_READY_OUT;

  // Running sum update once the oldest reading is out of the store
  logic [31:0] old_w;
  wire full = (fill_r >= len_eff);
  wire signed [SW-1:0] sum_nxt = full ? sum_r + SW'(samp_r) - SW'($signed(old_w))
                                      : sum_r + SW'(samp_r);
  wire [10:0] fill_nxt = full ? fill_r : fill_r + 11'h1;
  wire [SW-1:0] sum_mag = sum_nxt[SW-1] ? SW'(-sum_nxt) : SW'(sum_nxt);
  wire [9:0] wptr_nxt = (11'(wptr_r) + 11'h1 >= len_eff) ? 10'h0 : wptr_r + 10'h1;

  // Averaging divider and gain/loss reciprocal divider
  logic          avg_done, rcp_busy, rcp_done, sum_neg_r;
  logic [SW-1:0] avg_q;
  logic [RW-1:0] rcp_q;
  wire start_avg = (state_r == pal_pkg::ST_ACC);
  wire start_rcp = (wr_gain || wr_loss) && ctrl_r.units_lin && !rcp_busy;

  pal_avg_mem #(.DW(32), .AW(10)) u_mem (
    .CLOCK_IN    (CLOCK_IN),
    .wr_en_in    (start_avg),
    .wr_addr_in  (wptr_r),
    .wr_data_in  (samp_r),
    .rd_addr_in  (wptr_r),
    .rd_data_out (old_w)
  );

  pal_div #(.W(SW)) u_avg_div (
    .CLOCK_IN    (CLOCK_IN),
    .rst_b_in    (RST_B_IN),
    .start_in    (start_avg),
    .dividend_in (sum_mag),
    .divisor_in  (SW'(fill_nxt)),
    .busy_out    (),
    .done_out    (avg_done),
    .quot_out    (avg_q)
  );

  pal_div #(.W(RW)) u_rcp_div (
    .CLOCK_IN    (CLOCK_IN),
    .rst_b_in    (RST_B_IN),
    .start_in    (start_rcp),
    .dividend_in (RW'(64'h1_0000_0000)),
    .divisor_in  (RW'(wval)),
    .busy_out    (rcp_busy),
    .done_out    (rcp_done),
    .quot_out    (rcp_q)
  );

  // Math then display offset on the filtered value
  wire signed [31:0] avg_s   = sum_neg_r ? -$signed(avg_q[31:0]) : $signed(avg_q[31:0]);
  wire signed [31:0] math_v  = (ctrl_r.math_mode != 2'h0) ? avg_s - ref_r : avg_s;
  wire signed [31:0] disp_v  = ctrl_r.disp_off_en ? math_v + disp_off_r : math_v;
  wire over_w  = ctrl_r.lim_on && (result_r > lim_up_r);
  wire under_w = ctrl_r.lim_on && (result_r < lim_lo_r);
  wire fail_ev = (state_r == pal_pkg::ST_CHK) && (over_w || under_w)
                 && (!ctrl_r.tdly_auto || settled);
  wire flush   = (state_r == pal_pkg::ST_IDLE) && (len_eff != len_prev_r);

  // Next state of the sample path
  pal_pkg::pal_state_e state_nxt;
  always_comb begin
    case (state_r)
      pal_pkg::ST_IDLE: state_nxt = take ? pal_pkg::ST_READ : pal_pkg::ST_IDLE;
      pal_pkg::ST_READ: state_nxt = pal_pkg::ST_ACC;
      pal_pkg::ST_ACC:  state_nxt = pal_pkg::ST_DIV;
      pal_pkg::ST_DIV:  state_nxt = avg_done ? pal_pkg::ST_CHK : pal_pkg::ST_DIV;
      pal_pkg::ST_CHK:  state_nxt = pal_pkg::ST_IDLE;
      default:          state_nxt = pal_pkg::ST_IDLE;
    endcase
  end

  // Sample path registers
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      state_r    <= pal_pkg::ST_IDLE;
      samp_r     <= '0;
      sum_r      <= '0;
      fill_r     <= '0;
      wptr_r     <= '0;
      len_prev_r <= `PAL_LEN_MIN;
      sum_neg_r  <= 1'b0;
      result_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (flush) begin                      // Length change restarts the filter
        sum_r      <= '0;
        fill_r     <= '0;
        wptr_r     <= '0;
        len_prev_r <= len_eff;
      end
      if (take) samp_r <= samp_off;
      if (start_avg) begin
        sum_r     <= sum_nxt;
        fill_r    <= fill_nxt;
        wptr_r    <= wptr_nxt;
        sum_neg_r <= sum_nxt[SW-1];
      end
      if (avg_done) result_r <= disp_v;
    end
  end

  // Range selection, manual or automatic
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      range_upper_r <= 1'b0;
    end else if (!ctrl_r.range_auto) begin
      range_upper_r <= ctrl_r.range_manual;
    end else if (avg_done) begin
      range_upper_r <= (avg_s >= RANGE_SWITCH);
    end
  end

  // Configuration registers written by software
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      ctrl_r     <= pal_pkg::pal_ctrl_s'(`PAL_CTRL_RST);
      res_r      <= `PAL_RES_RST;
      avg_len_r  <= `PAL_AVG_LEN_RST;
      gain_r     <= '0;
      loss_r     <= '0;
      disp_off_r <= '0;
      lim_up_r   <= `PAL_DBM_DEF_UP;
      lim_lo_r   <= `PAL_DBM_DEF_LO;
      ref_r      <= '0;
      lcfg_r     <= '0;
      recip_to_gain_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_w;
      if (units_chg) begin
        lim_up_r <= ctrl_w.units_db ? `PAL_DB_DEF_UP : `PAL_DBM_DEF_UP;
        lim_lo_r <= ctrl_w.units_db ? `PAL_DB_DEF_LO : `PAL_DBM_DEF_LO;
      end
      if (wr_res && WDATA_IN >= 32'h1 && WDATA_IN <= 32'h4) begin
        res_r <= WDATA_IN[2:0];
      end
      if (wr_len && len_ok) begin
        avg_len_r       <= wlen;
        ctrl_r.avg_auto <= 1'b0;
      end
      if (wr_gain) begin
        gain_r             <= wval;
        loss_r             <= -wval;
        ctrl_r.chan_off_en <= 1'b1;
        recip_to_gain_r    <= 1'b0;
      end
      if (wr_loss) begin
        loss_r             <= wval;
        gain_r             <= -wval;
        ctrl_r.chan_off_en <= 1'b1;
        recip_to_gain_r    <= 1'b1;
      end
      if (rcp_done && recip_to_gain_r) gain_r <= $signed(rcp_q[31:0]);
      if (rcp_done && !recip_to_gain_r) loss_r <= $signed(rcp_q[31:0]);
      if (wr_disp) begin
        disp_off_r         <= wval;
        ctrl_r.disp_off_en <= 1'b1;
      end
      if (wr_up && lim_ok) lim_up_r <= wval;
      if (wr_lo && lim_ok) lim_lo_r <= wval;
      if (wr_ref) ref_r <= wval;
      if (wr_lcfg) lcfg_r <= WDATA_IN[7:0];  // Both outputs, four bits each
    end
  end

  // Auto filter length lookup, writable per resolution and power band
  wire [3:0] tab_idx = WDATA_IN[`PAL_TAB_IDX_LSB +: 4];
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_tab
      always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
          tab_r[gi] <= `PAL_TAB_RST;
        end else if (wr_tab && tab_idx == 4'(gi) && wlen >= `PAL_LEN_MIN
                     && wlen <= `PAL_LEN_MAX) begin
          tab_r[gi] <= wlen;
        end
      end
    end
  endgenerate

  // Fail flag, event and saturating counter; a new failure wins over a clear
  wire clr_fail  = wr_stat && WDATA_IN[`PAL_ST_FAIL];
  wire clr_event = wr_stat && WDATA_IN[`PAL_ST_EVENT];
  wire clr_cnt   = wr_stat && WDATA_IN[`PAL_ST_CNT_CLR];
  wire cnt_max   = &fcount_r;
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      fail_r   <= 1'b0;
      event_r  <= 1'b0;
      fcount_r <= '0;
      over_r   <= 1'b0;
      under_r  <= 1'b0;
    end else begin
      fail_r  <= fail_ev | (fail_r & ~clr_fail);
      event_r <= fail_ev | (event_r & ~clr_event);
      if (fail_ev) begin
        fcount_r <= clr_cnt ? `PAL_FCNT_W'(1) :
                    cnt_max ? fcount_r : fcount_r + 1'b1;
      end else if (clr_cnt) begin
        fcount_r <= '0;
      end
      if (state_r == pal_pkg::ST_CHK) begin
        over_r  <= over_w;
        under_r <= under_w;
      end
    end
  end

  // Logic limit outputs: source, enable and polarity per output
  logic [1:0] lout_nxt;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lout
      wire cond = (lcfg_r[gi].src[0] & over_r) | (lcfg_r[gi].src[1] & under_r);
      assign lout_nxt[gi] = (lcfg_r[gi].en & cond) ~^ lcfg_r[gi].act_high;
    end
  endgenerate

  // Read mux
  wire [31:0] status_w = 32'({under_r, over_r, settled, range_upper_r, 1'b0,
                              event_r, fail_r});
  logic [31:0] rd_mux;
  always_comb begin
    case (ADDR_IN)
      `PAL_OFF_CTRL:      rd_mux = 32'(ctrl_r);
      `PAL_OFF_RES:       rd_mux = 32'(res_r);
      `PAL_OFF_AVG_LEN:   rd_mux = 32'(avg_len_r);
      `PAL_OFF_CH_GAIN:   rd_mux = gain_r;
      `PAL_OFF_CH_LOSS:   rd_mux = loss_r;
      `PAL_OFF_DISP_OFF:  rd_mux = disp_off_r;
      `PAL_OFF_LIM_UP:    rd_mux = lim_up_r;
      `PAL_OFF_LIM_LO:    rd_mux = lim_lo_r;
      `PAL_OFF_MATH_REF:  rd_mux = ref_r;
      `PAL_OFF_LOGIC_CFG: rd_mux = 32'(lcfg_r);
      `PAL_OFF_STATUS:    rd_mux = status_w;
      `PAL_OFF_FCOUNT:    rd_mux = 32'(fcount_r);
      `PAL_OFF_RESULT:    rd_mux = result_r;
      `PAL_OFF_EFF_LEN:   rd_mux = 32'(len_eff);
      default:            rd_mux = 32'h0;
    endcase
  end

  // Output flops
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT        <= 32'h0;
      SAMPLE_READY_OUT <= 1'b0;
      RESULT_OUT       <= 32'h0;
      RESULT_VALID_OUT <= 1'b0;
      RANGE_UPPER_OUT  <= 1'b0;
      LOGIC_OUT        <= 2'h0;
      SRQ_OUT          <= 1'b0;
    end else begin
      RDATA_OUT        <= RD_IN ? rd_mux : 32'h0;
      SAMPLE_READY_OUT <= (state_nxt == pal_pkg::ST_IDLE) && !take;
      RESULT_OUT       <= avg_done ? disp_v : RESULT_OUT;
      RESULT_VALID_OUT <= avg_done;
      RANGE_UPPER_OUT  <= range_upper_r;
      LOGIC_OUT        <= lout_nxt;
      SRQ_OUT          <= event_r & ctrl_r.srq_en;
    end
  end

endmodule : pal_limit_path

//--- test/pal_limit_path_chk.sv
// Port checker of the limit path: read data slot and sample stream timing.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ps
module pal_limit_path_chk (
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        SAMPLE_VALID_IN,
  input wire logic        SAMPLE_READY_OUT,
  input wire logic [31:0] RESULT_OUT,
  input wire logic        RESULT_VALID_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);
  // A reading taken by the block
  sequence s_take; SAMPLE_VALID_IN && SAMPLE_READY_OUT; endsequence
  // Read slot, result latency, busy window and result hold
  property p_rd_idle; !$past(RD_IN) |-> RDATA_OUT == 32'h0; endproperty
  property p_lat; s_take |-> ##48 RESULT_VALID_OUT; endproperty
  property p_quiet; s_take |=> !RESULT_VALID_OUT [*8]; endproperty
  property p_busy; s_take |=> !SAMPLE_READY_OUT [*8]; endproperty
  property p_back; RESULT_VALID_OUT |-> ##[1:4] SAMPLE_READY_OUT; endproperty
  property p_pulse; RESULT_VALID_OUT |=> !RESULT_VALID_OUT; endproperty
  property p_hold; !RESULT_VALID_OUT |-> $stable(RESULT_OUT); endproperty
  property p_excl; RESULT_VALID_OUT |-> !SAMPLE_READY_OUT; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data off slot");
  a_lat: assert property (p_lat) else $error("result latency");
  a_quiet: assert property (p_quiet) else $error("early result");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_back: assert property (p_back) else $error("ready not back");
  a_pulse: assert property (p_pulse) else $error("result pulse long");
  a_hold: assert property (p_hold) else $error("result moved");
  a_excl: assert property (p_excl) else $error("ready with result");
endmodule : pal_limit_path_chk

//--- test/pal_sensor_model.sv
// Sensor front end: offers one reading per request, holds it until taken.
// Assumes a take when valid and ready meet at a rising edge.
`timescale 1ns/1ps
module pal_sensor_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ready_in,
  input  wire logic        go_in,
  input  wire logic [31:0] value_in,
  output logic             valid_out,
  output logic      [31:0] sample_out
);
  // Hold until taken, then invert so stale data never looks valid
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      valid_out  <= 1'b0;
      sample_out <= 32'h0;
    end else if (go_in) begin
      valid_out  <= 1'b1;
      sample_out <= value_in;
    end else if (valid_out && ready_in) begin
      valid_out  <= 1'b0;
      sample_out <= ~sample_out;
    end
  end
endmodule : pal_sensor_model

//--- test/pal_limit_path_tb_top.sv
// Testbench of the limit path: host register tasks, one task per scenario.
// Assumes the sensor model feeds the sample stream.
`timescale 1ns/1ps
module pal_limit_path_tb_top;
  logic        CLOCK_IN = 1'b0;
  logic        RST_B_IN = 1'b0;
  logic        WR_IN = 1'b0;
  logic        RD_IN = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  ADDR_IN = 8'h0;
  logic [31:0] WDATA_IN = 32'h0;
  logic [31:0] val = 32'h0;
  logic [31:0] RDATA_OUT, SAMPLE_IN, RESULT_OUT;
  logic        SAMPLE_VALID_IN, SAMPLE_READY_OUT, RESULT_VALID_OUT, RANGE_UPPER_OUT, SRQ_OUT;
  logic [1:0]  LOGIC_OUT;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Clock and the two parties
  always #12.5 CLOCK_IN = ~CLOCK_IN;
  pal_limit_path i_dut (.CLOCK_IN, .RST_B_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
    .SAMPLE_VALID_IN, .SAMPLE_IN, .SAMPLE_READY_OUT, .RESULT_OUT, .RESULT_VALID_OUT,
    .RANGE_UPPER_OUT, .LOGIC_OUT, .SRQ_OUT);
  pal_sensor_model i_sen (.clk_in(CLOCK_IN), .rst_b_in(RST_B_IN), .ready_in(SAMPLE_READY_OUT),
    .go_in(go), .value_in(val), .valid_out(SAMPLE_VALID_IN), .sample_out(SAMPLE_IN));
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge CLOCK_IN);
    WR_IN    <= 1'b0;
  endtask : wr
  // One-cycle register read, data judged in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
    @(posedge CLOCK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    @(posedge CLOCK_IN);
    RD_IN   <= 1'b0;
    #1;
    chk(RDATA_OUT & m, e);
  endtask : rdc
  // One reading through the path: result, logic outputs, fail count
  task automatic samp(input logic [31:0] v, input logic [31:0] e, input logic [1:0] lg,
                      input logic [31:0] c);
    @(posedge CLOCK_IN);
    val <= v;
    go  <= 1'b1;
    @(posedge CLOCK_IN);
    go  <= 1'b0;
    for (int n = 0; RESULT_VALID_OUT !== 1'b1; n++) begin
      if (n == 200) give_verdict(1'b1);
      @(posedge CLOCK_IN);
      #1;
    end
    chk(RESULT_OUT, e);
    repeat (4) @(posedge CLOCK_IN);
    #1;
    chk({30'h0, LOGIC_OUT}, {30'h0, lg});
    rdc(8'h30, c);
  endtask : samp
  // Reset values
  task automatic t_reset;
    logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1c, 8'h30};
    logic [31:0] e [6] = '{32'h7, 32'h3, 32'h1, 32'h15f90, 32'hfffea070, 32'h0};
    for (int i = 0; i < 6; i++) rdc(a[i], e[i]);
    rdc(8'h38, 32'h4);
    wr(8'h28, 32'h000b0010);
    rdc(8'h38, 32'h10);
    $display("t_reset done");
  endtask : t_reset
  // Length, resolution, coupling, span refusals and manual range
  task automatic t_cfg;
    wr(8'h08, 32'h4);
    rdc(8'h00, 32'h5);
    wr(8'h08, 32'h401);
    rdc(8'h08, 32'h4);
    wr(8'h04, 32'h5);
    rdc(8'h04, 32'h3);
    wr(8'h0c, 32'hffffd8f0);
    rdc(8'h10, 32'h2710);
    rdc(8'h00, 32'h805);
    wr(8'h18, 32'h38271);
    rdc(8'h18, 32'h15f90);
    wr(8'h00, 32'h118);
    rdc(8'h00, 32'h118);
    rdc(8'h2c, 32'h8, 32'h8);
    chk({31'h0, RANGE_UPPER_OUT}, 32'h1);
    wr(8'h00, 32'h110);
    rdc(8'h00, 32'h110);
    chk({31'h0, RANGE_UPPER_OUT}, 32'h0);
    wr(8'h00, 32'h20);
    wr(8'h0c, 32'h20000);
    repeat (45) @(posedge CLOCK_IN);
    rdc(8'h10, 32'h8000);
    $display("t_cfg done");
  endtask : t_cfg
  // Over, boundary and under readings, flag, request and clear
  task automatic t_limit;
    wr(8'h00, 32'h114);
    wr(8'h18, 32'hffffd8f0);
    wr(8'h1c, 32'hffff8ad0);
    wr(8'h24, 32'hf);
    samp(32'hffffec78, 32'hffffec78, 2'b11, 32'h1);
    chk({31'h0, SRQ_OUT}, 32'h1);
    chk({31'h0, RANGE_UPPER_OUT}, 32'h1);
    samp(32'hffffd8f0, 32'hffffd8f0, 2'b10, 32'h1);
    samp(32'hffff63c0, 32'hffff63c0, 2'b11, 32'h2);
    chk({31'h0, RANGE_UPPER_OUT}, 32'h0);
    rdc(8'h2c, 32'h1, 32'h1);
    wr(8'h2c, 32'h7);
    rdc(8'h30, 32'h0);
    chk({31'h0, SRQ_OUT}, 32'h0);
    $display("t_limit done");
  endtask : t_limit
  // Display offset with and without math, and switched off
  task automatic t_path;
    wr(8'h14, 32'h3e8);
    samp(32'hffffb1e0, 32'hffffb5c8, 2'b10, 32'h0);
    wr(8'h20, 32'h1388);
    wr(8'h00, 32'h1314);
    samp(32'hffffb1e0, 32'hffffa240, 2'b10, 32'h0);
    wr(8'h00, 32'h114);
    samp(32'hffffb1e0, 32'hffffb1e0, 2'b10, 32'h0);
    $display("t_path done");
  endtask : t_path
  // Counts, verdict and end of run
  task automatic give_verdict(input logic hung);
    if (hung) n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge CLOCK_IN);
    RST_B_IN <= 1'b1;
    t_reset();
    t_cfg();
    t_limit();
    t_path();
    give_verdict(1'b0);
  end
endmodule : pal_limit_path_tb_top

bind pal_limit_path pal_limit_path_chk i_chk (.CLOCK_IN, .RST_B_IN, .RD_IN, .RDATA_OUT,
  .SAMPLE_VALID_IN, .SAMPLE_READY_OUT, .RESULT_OUT, .RESULT_VALID_OUT);
